// >>> inc/tpuc_pkg.sv
package tpuc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h02;
	localparam logic [7:0] ADDR_PRIMARY_SETUP = 8'h10;
	localparam logic [7:0] ADDR_SECONDARY_SETUP = 8'h11;
	localparam logic [7:0] ADDR_GRAB = 8'h14;
	localparam logic [7:0] ADDR_PIXFMT = 8'h16;
	localparam logic [7:0] ADDR_OUTFMT = 8'h17;
	localparam logic [7:0] ADDR_OPSEL = 8'h18;
	localparam logic [7:0] ADDR_FINE_HI = 8'h20;
	localparam logic [7:0] ADDR_FINE_LO = 8'h21;
	localparam logic [7:0] ADDR_COARSE_HI = 8'h22;
	localparam logic [7:0] ADDR_COARSE_LO = 8'h23;
	localparam logic [7:0] ADDR_GAIN = 8'h24;
	localparam logic [7:0] ADDR_CLKDIV = 8'h25;
	localparam logic [7:0] ADDR_PIXOFF_HI = 8'h2c;
	localparam logic [7:0] ADDR_PIXOFF_LO = 8'h2d;
	localparam logic [7:0] ADDR_LINE_HI = 8'h52;
	localparam logic [7:0] ADDR_LINE_LO = 8'h53;
	localparam logic [7:0] ADDR_HOFF_HI = 8'h57;
	localparam logic [7:0] ADDR_HOFF_LO = 8'h58;
	localparam logic [7:0] ADDR_VOFF_HI = 8'h59;
	localparam logic [7:0] ADDR_VOFF_LO = 8'h5a;
	localparam logic [7:0] ADDR_FIELD_HI = 8'h61;
	localparam logic [7:0] ADDR_FIELD_LO = 8'h62;

	// ==========================================================
	// Pending flag positions in the status register
	localparam int PEND_FINE = 0;
	localparam int PEND_COARSE = 1;
	localparam int PEND_CLKDIV = 2;
	localparam int PEND_GAIN = 3;
	localparam int PEND_PAN = 4;
	localparam int PEND_TILT = 5;
	localparam int PEND_VIDEO = 6;
	localparam int NUM_PEND = 7;

	// ==========================================================
	// Field positions and encodings
	localparam int PRIMARY_SETUP_MODE_LSB = 0;
	localparam int PRIMARY_SETUP_QCIF_SUB_BIT = 2;
	localparam int SECONDARY_SETUP_HSHUFFLE_BIT = 0;
	localparam int PIXFMT_HMIRROR_BIT = 0;
	localparam int PIXFMT_HSHUFFLE_BIT = 1;
	localparam logic [1:0] MODE_PAL_NTSC = 2'h0;
	localparam logic [1:0] MODE_CIF = 2'h1;
	localparam logic [1:0] MODE_QCIF = 2'h2;
	localparam logic [3:0] CLKDIV_HI_PAL_NTSC = 4'h0;
	localparam logic [3:0] CLKDIV_HI_CIF = 4'h1;
	localparam logic [3:0] CLKDIV_HI_QCIF = 4'h3;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [15:0] REG16_RST = 16'h0000;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		REQ_WRITE = 2'b00,
		REQ_READ = 2'b01,
		REQ_MSG_END = 2'b10
	} tpuc_kind_t;

	typedef struct packed {
		tpuc_kind_t kind;
		logic auto_inc;
		logic [7:0] addr;
		logic [7:0] data;
	} tpuc_req_t;

	typedef struct packed {
		logic [7:0] primary_setup;
		logic [7:0] secondary_setup;
		logic [7:0] grab;
		logic [7:0] pix_fmt;
		logic [7:0] out_fmt;
		logic [7:0] op_sel;
		logic [15:0] pix_off;
		logic [15:0] line_len;
		logic [15:0] field_len;
		logic [15:0] fine;
		logic [15:0] coarse;
		logic [7:0] gain;
		logic [7:0] clkdiv;
		logic [15:0] hoff;
		logic [15:0] voff;
	} tpuc_regs_t;

	localparam tpuc_regs_t REGS_RST = '{REG_RST, REG_RST, REG_RST, REG_RST, REG_RST, REG_RST,
		REG16_RST, REG16_RST, REG16_RST, REG16_RST, REG16_RST, REG_RST, REG_RST, REG16_RST, REG16_RST};
endpackage : tpuc_pkg

// >>> design/tpuc_link_cdc.sv
`timescale 1ns/1ns
`default_nettype none
module tpuc_link_cdc (
	input wire logic clk_sys_in,
	input wire logic clk_link_in,
	input wire logic rst_b_in,
	input wire logic link_valid_in,
	input wire tpuc_pkg::tpuc_req_t link_pkt_in,
	output logic link_busy_out,
	output logic link_rsp_valid_out,
	output logic [7:0] link_rsp_data_out,
	output logic sys_evt_out,
	output tpuc_pkg::tpuc_req_t sys_pkt_out,
	input wire logic [7:0] sys_rdata_in
);
	// ==========================================================
	// Link side: one request in flight, held until acknowledged
	tpuc_pkg::tpuc_req_t pkt_q;
	logic req_tgl_q;
	logic ack_s1_q, ack_s2_q, ack_s3_q;
	logic ack_tgl_q;
	logic [7:0] rdata_q;
	logic req_s1_q, req_s2_q, req_s3_q;
	logic ack_edge, req_edge;

	assign ack_edge = ack_s2_q ^ ack_s3_q;
	assign req_edge = req_s2_q ^ req_s3_q;

	always_ff @(posedge clk_link_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	always_ff @(posedge clk_link_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pkt_q <= '0;
			req_tgl_q <= 1'b0;
			link_busy_out <= 1'b0;
		end else if (link_valid_in && !link_busy_out) begin
			pkt_q <= link_pkt_in;
			req_tgl_q <= ~req_tgl_q;
			link_busy_out <= 1'b1;
		end else if (ack_edge) begin
			link_busy_out <= 1'b0;
		end
	end

	// Read word is stable in the system domain until the next request
	always_ff @(posedge clk_link_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link_rsp_valid_out <= 1'b0;
			link_rsp_data_out <= 8'h00;
		end else begin
			link_rsp_valid_out <= ack_edge;
			if (ack_edge) begin
				link_rsp_data_out <= rdata_q;
			end
		end
	end

	// ==========================================================
	// System side: toggle seen, packet taken, answer returned
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			sys_evt_out <= 1'b0;
			sys_pkt_out <= '0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			sys_evt_out <= req_edge;
			if (req_edge) begin
				sys_pkt_out <= pkt_q;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_q <= 8'h00;
			ack_tgl_q <= 1'b0;
		end else if (sys_evt_out) begin
			rdata_q <= sys_rdata_in;
			ack_tgl_q <= ~ack_tgl_q;
		end
	end
endmodule : tpuc_link_cdc
`default_nettype wire

// >>> design/tpuc_update_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Writes land any time; they take effect only at update points unless immediate.
// - Immediate gain or clock division applies when the serial message ends.
// - Fine and coarse exposure are always timed; no immediate path.
// - Exposure shows in read-out one frame after loading; gain has no latency.
// - Gain loads about one frame after exposure so both hit one frame.
// - No transfer happens while an auto-increment write message is in progress.
// - Gain transfer at its point is suppressed during an auto-increment message.
// - Only working registers drive the sensor; writes go to shadows.
// - One pending flag per category in status register 2; high means not loaded.
// - Fine exposure is registers 32,33; coarse exposure is registers 34,35.
// - Gain is register 36 alone; clock division is register 37 alone.
// - Pan pending: horizontal offset always; setup, shuffle, mirror only on change.
// - Tilt pending: vertical offset always; QCIF subsample or shuffle/mirror change.
// - Any write to video timing registers sets the video timing pending flag.
// - Fine exposure at odd-to-even if line length pending, else odd EOF line.
// - Coarse exposure loads in active video start of odd field first dark line.
// - Clock division and video timing load at the odd-to-even field transition.
// - Gain and pan load in active video start of the odd field EOF line.
// - Tilt loads in active video start of the odd field first visible line.
// - Order: coarse, tilt, gain/pan/fine, then clock division/video/fine.
// - Odd and even fields are tracked in every mode, equal lengths included.
// - Clock divisor upper nibble follows video mode; software writes low nibble.
module tpuc_update_ctrl (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic clk_link_in,
	input wire logic link_valid_in,
	input wire tpuc_pkg::tpuc_req_t link_pkt_in,
	output logic link_busy_out,
	output logic link_rsp_valid_out,
	output logic [7:0] link_rsp_data_out,
	input wire logic gain_imm_in,
	input wire logic clkdiv_imm_in,
	input wire logic field_start_in,
	input wire logic sav_in,
	input wire logic line_first_dark_in,
	input wire logic line_first_visible_in,
	input wire logic line_eof_in,
	output tpuc_pkg::tpuc_regs_t work_out,
	output logic [6:0] pend_out,
	output logic field_odd_out,
	output logic burst_out
);
	// ==========================================================
	// Helpers
	function automatic logic [3:0] clkdiv_hi(input logic [7:0] setup);
		logic [1:0] mode;
		mode = setup[tpuc_pkg::PRIMARY_SETUP_MODE_LSB +: 2];
		if (mode == tpuc_pkg::MODE_CIF) begin
			clkdiv_hi = tpuc_pkg::CLKDIV_HI_CIF;
		end else if (mode == tpuc_pkg::MODE_PAL_NTSC) begin
			clkdiv_hi = tpuc_pkg::CLKDIV_HI_PAL_NTSC;
		end else begin
			clkdiv_hi = tpuc_pkg::CLKDIV_HI_QCIF;
		end
	endfunction : clkdiv_hi

	function automatic logic differs(input logic [7:0] a, input logic [7:0] b, input int pos);
		differs = a[pos] ^ b[pos];
	endfunction : differs

	// ==========================================================
	// Link crossing
	logic sys_evt;
	tpuc_pkg::tpuc_req_t sys_pkt;
	logic [7:0] rd_data;

	tpuc_link_cdc u_cdc (
		.clk_sys_in(clk_sys_in),
		.clk_link_in(clk_link_in),
		.rst_b_in(rst_b_in),
		.link_valid_in(link_valid_in),
		.link_pkt_in(link_pkt_in),
		.link_busy_out(link_busy_out),
		.link_rsp_valid_out(link_rsp_valid_out),
		.link_rsp_data_out(link_rsp_data_out),
		.sys_evt_out(sys_evt),
		.sys_pkt_out(sys_pkt),
		.sys_rdata_in(rd_data)
	);

	// ==========================================================
	// Decode
	tpuc_pkg::tpuc_regs_t shadow_q;
	logic [6:0] pend_set, pend_clr;
	logic wr, msg_end;
	logic [7:0] wa, wd;
	logic pt_coarse, pt_tilt, pt_eof, pt_oe, allow;
	logic line_chg_q;

	assign wr = sys_evt && (sys_pkt.kind == tpuc_pkg::REQ_WRITE);
	assign msg_end = sys_evt && (sys_pkt.kind == tpuc_pkg::REQ_MSG_END);
	assign wa = sys_pkt.addr;
	assign wd = sys_pkt.data;

	// ==========================================================
	// Message tracking
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			burst_out <= 1'b0;
		end else if (msg_end) begin
			burst_out <= 1'b0;
		end else if (wr && sys_pkt.auto_inc) begin
			burst_out <= 1'b1;
		end
	end

	// ==========================================================
	// Field parity and update points
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			field_odd_out <= 1'b0;
		end else if (field_start_in) begin
			field_odd_out <= ~field_odd_out;
		end
	end

	// Points fall in field order coarse, tilt, EOF, odd-to-even
	always_comb begin
		allow = !burst_out;
		pt_coarse = sav_in && line_first_dark_in && field_odd_out;
		pt_tilt = sav_in && line_first_visible_in && field_odd_out;
		pt_eof = sav_in && line_eof_in && field_odd_out;
		pt_oe = field_start_in && field_odd_out;
	end

	// ==========================================================
	// Shadow registers
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shadow_q <= tpuc_pkg::REGS_RST;
		end else if (wr) begin
			unique case (wa)
				tpuc_pkg::ADDR_PRIMARY_SETUP: begin
					shadow_q.primary_setup <= wd;
					shadow_q.clkdiv[7:4] <= clkdiv_hi(wd);
				end
				tpuc_pkg::ADDR_SECONDARY_SETUP: shadow_q.secondary_setup <= wd;
				tpuc_pkg::ADDR_GRAB: shadow_q.grab <= wd;
				tpuc_pkg::ADDR_PIXFMT: shadow_q.pix_fmt <= wd;
				tpuc_pkg::ADDR_OUTFMT: shadow_q.out_fmt <= wd;
				tpuc_pkg::ADDR_OPSEL: shadow_q.op_sel <= wd;
				tpuc_pkg::ADDR_FINE_HI: shadow_q.fine[15:8] <= wd;
				tpuc_pkg::ADDR_FINE_LO: shadow_q.fine[7:0] <= wd;
				tpuc_pkg::ADDR_COARSE_HI: shadow_q.coarse[15:8] <= wd;
				tpuc_pkg::ADDR_COARSE_LO: shadow_q.coarse[7:0] <= wd;
				tpuc_pkg::ADDR_GAIN: shadow_q.gain <= wd;
				tpuc_pkg::ADDR_CLKDIV: shadow_q.clkdiv[3:0] <= wd[3:0];
				tpuc_pkg::ADDR_PIXOFF_HI: shadow_q.pix_off[15:8] <= wd;
				tpuc_pkg::ADDR_PIXOFF_LO: shadow_q.pix_off[7:0] <= wd;
				tpuc_pkg::ADDR_LINE_HI: shadow_q.line_len[15:8] <= wd;
				tpuc_pkg::ADDR_LINE_LO: shadow_q.line_len[7:0] <= wd;
				tpuc_pkg::ADDR_HOFF_HI: shadow_q.hoff[15:8] <= wd;
				tpuc_pkg::ADDR_HOFF_LO: shadow_q.hoff[7:0] <= wd;
				tpuc_pkg::ADDR_VOFF_HI: shadow_q.voff[15:8] <= wd;
				tpuc_pkg::ADDR_VOFF_LO: shadow_q.voff[7:0] <= wd;
				tpuc_pkg::ADDR_FIELD_HI: shadow_q.field_len[15:8] <= wd;
				tpuc_pkg::ADDR_FIELD_LO: shadow_q.field_len[7:0] <= wd;
				default: ;
			endcase
		end
	end

	// Status and unmapped addresses ignore writes
	always_comb begin
		unique case (sys_pkt.addr)
			tpuc_pkg::ADDR_STATUS: rd_data = {1'b0, pend_out};
			tpuc_pkg::ADDR_PRIMARY_SETUP: rd_data = shadow_q.primary_setup;
			tpuc_pkg::ADDR_SECONDARY_SETUP: rd_data = shadow_q.secondary_setup;
			tpuc_pkg::ADDR_GRAB: rd_data = shadow_q.grab;
			tpuc_pkg::ADDR_PIXFMT: rd_data = shadow_q.pix_fmt;
			tpuc_pkg::ADDR_OUTFMT: rd_data = shadow_q.out_fmt;
			tpuc_pkg::ADDR_OPSEL: rd_data = shadow_q.op_sel;
			tpuc_pkg::ADDR_FINE_HI: rd_data = shadow_q.fine[15:8];
			tpuc_pkg::ADDR_FINE_LO: rd_data = shadow_q.fine[7:0];
			tpuc_pkg::ADDR_COARSE_HI: rd_data = shadow_q.coarse[15:8];
			tpuc_pkg::ADDR_COARSE_LO: rd_data = shadow_q.coarse[7:0];
			tpuc_pkg::ADDR_GAIN: rd_data = shadow_q.gain;
			tpuc_pkg::ADDR_CLKDIV: rd_data = shadow_q.clkdiv;
			tpuc_pkg::ADDR_PIXOFF_HI: rd_data = shadow_q.pix_off[15:8];
			tpuc_pkg::ADDR_PIXOFF_LO: rd_data = shadow_q.pix_off[7:0];
			tpuc_pkg::ADDR_LINE_HI: rd_data = shadow_q.line_len[15:8];
			tpuc_pkg::ADDR_LINE_LO: rd_data = shadow_q.line_len[7:0];
			tpuc_pkg::ADDR_HOFF_HI: rd_data = shadow_q.hoff[15:8];
			tpuc_pkg::ADDR_HOFF_LO: rd_data = shadow_q.hoff[7:0];
			tpuc_pkg::ADDR_VOFF_HI: rd_data = shadow_q.voff[15:8];
			tpuc_pkg::ADDR_VOFF_LO: rd_data = shadow_q.voff[7:0];
			tpuc_pkg::ADDR_FIELD_HI: rd_data = shadow_q.field_len[15:8];
			tpuc_pkg::ADDR_FIELD_LO: rd_data = shadow_q.field_len[7:0];
			default: rd_data = 8'h00;
		endcase
	end

	// ==========================================================
	// Pending flags
	always_comb begin
		pend_set = 7'h00;
		if (wr) begin
			pend_set[tpuc_pkg::PEND_FINE] = (wa == tpuc_pkg::ADDR_FINE_HI) || (wa == tpuc_pkg::ADDR_FINE_LO);
			pend_set[tpuc_pkg::PEND_COARSE] = (wa == tpuc_pkg::ADDR_COARSE_HI) || (wa == tpuc_pkg::ADDR_COARSE_LO);
			pend_set[tpuc_pkg::PEND_GAIN] = (wa == tpuc_pkg::ADDR_GAIN);
			pend_set[tpuc_pkg::PEND_CLKDIV] = (wa == tpuc_pkg::ADDR_CLKDIV);
			pend_set[tpuc_pkg::PEND_PAN] = (wa == tpuc_pkg::ADDR_HOFF_HI) || (wa == tpuc_pkg::ADDR_HOFF_LO)
				|| ((wa == tpuc_pkg::ADDR_PRIMARY_SETUP) && differs(wd, shadow_q.primary_setup, tpuc_pkg::PRIMARY_SETUP_QCIF_SUB_BIT))
				|| ((wa == tpuc_pkg::ADDR_SECONDARY_SETUP) && differs(wd, shadow_q.secondary_setup, tpuc_pkg::SECONDARY_SETUP_HSHUFFLE_BIT))
				|| ((wa == tpuc_pkg::ADDR_PIXFMT) && differs(wd, shadow_q.pix_fmt, tpuc_pkg::PIXFMT_HMIRROR_BIT));
			pend_set[tpuc_pkg::PEND_TILT] = (wa == tpuc_pkg::ADDR_VOFF_HI) || (wa == tpuc_pkg::ADDR_VOFF_LO)
				|| ((wa == tpuc_pkg::ADDR_PRIMARY_SETUP) && differs(wd, shadow_q.primary_setup, tpuc_pkg::PRIMARY_SETUP_QCIF_SUB_BIT))
				|| ((wa == tpuc_pkg::ADDR_PIXFMT) && (differs(wd, shadow_q.pix_fmt, tpuc_pkg::PIXFMT_HMIRROR_BIT)
				|| differs(wd, shadow_q.pix_fmt, tpuc_pkg::PIXFMT_HSHUFFLE_BIT)));
			pend_set[tpuc_pkg::PEND_VIDEO] = (wa == tpuc_pkg::ADDR_PRIMARY_SETUP) || (wa == tpuc_pkg::ADDR_SECONDARY_SETUP)
				|| (wa == tpuc_pkg::ADDR_GRAB) || (wa == tpuc_pkg::ADDR_PIXFMT) || (wa == tpuc_pkg::ADDR_OUTFMT)
				|| (wa == tpuc_pkg::ADDR_OPSEL) || (wa == tpuc_pkg::ADDR_PIXOFF_HI) || (wa == tpuc_pkg::ADDR_PIXOFF_LO)
				|| (wa == tpuc_pkg::ADDR_LINE_HI) || (wa == tpuc_pkg::ADDR_LINE_LO)
				|| (wa == tpuc_pkg::ADDR_FIELD_HI) || (wa == tpuc_pkg::ADDR_FIELD_LO);
		end
	end

	// Load strobes; exposure has no immediate path
	always_comb begin
		pend_clr = 7'h00;
		pend_clr[tpuc_pkg::PEND_COARSE] = allow && pt_coarse;
		pend_clr[tpuc_pkg::PEND_TILT] = allow && pt_tilt;
		// Gain waits for EOF so it meets the exposure one frame later
		pend_clr[tpuc_pkg::PEND_GAIN] = (allow && pt_eof) || (msg_end && gain_imm_in);
		pend_clr[tpuc_pkg::PEND_PAN] = allow && pt_eof;
		pend_clr[tpuc_pkg::PEND_FINE] = allow && (line_chg_q ? pt_oe : pt_eof);
		pend_clr[tpuc_pkg::PEND_CLKDIV] = (allow && pt_oe) || (msg_end && clkdiv_imm_in);
		pend_clr[tpuc_pkg::PEND_VIDEO] = allow && pt_oe;
		pend_clr = pend_clr & pend_out;
	end

	// Set wins over clear: a write on the load cycle stays pending
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pend_out <= 7'h00;
		end else begin
			pend_out <= (pend_out & ~pend_clr) | pend_set;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			line_chg_q <= 1'b0;
		end else if (wr && ((wa == tpuc_pkg::ADDR_LINE_HI) || (wa == tpuc_pkg::ADDR_LINE_LO))) begin
			line_chg_q <= 1'b1;
		end else if (pend_clr[tpuc_pkg::PEND_VIDEO]) begin
			line_chg_q <= 1'b0;
		end
	end

	// ==========================================================
	// Working registers
	// Exposure loaded here shows in read-out one frame on
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			work_out <= tpuc_pkg::REGS_RST;
		end else begin
			if (pend_clr[tpuc_pkg::PEND_FINE]) work_out.fine <= shadow_q.fine;
			if (pend_clr[tpuc_pkg::PEND_COARSE]) work_out.coarse <= shadow_q.coarse;
			if (pend_clr[tpuc_pkg::PEND_GAIN]) work_out.gain <= shadow_q.gain;
			if (pend_clr[tpuc_pkg::PEND_CLKDIV]) work_out.clkdiv <= shadow_q.clkdiv;
			if (pend_clr[tpuc_pkg::PEND_PAN]) work_out.hoff <= shadow_q.hoff;
			if (pend_clr[tpuc_pkg::PEND_TILT]) work_out.voff <= shadow_q.voff;
			if (pend_clr[tpuc_pkg::PEND_VIDEO]) begin
				work_out.primary_setup <= shadow_q.primary_setup;
				work_out.secondary_setup <= shadow_q.secondary_setup;
				work_out.grab <= shadow_q.grab;
				work_out.pix_fmt <= shadow_q.pix_fmt;
				work_out.out_fmt <= shadow_q.out_fmt;
				work_out.op_sel <= shadow_q.op_sel;
				work_out.pix_off <= shadow_q.pix_off;
				work_out.line_len <= shadow_q.line_len;
				work_out.field_len <= shadow_q.field_len;
			end
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_line_write;
		wr && ((wa == tpuc_pkg::ADDR_LINE_HI) || (wa == tpuc_pkg::ADDR_LINE_LO));
	endsequence

	sequence s_fine_oe;
		pt_oe && allow && pend_out[tpuc_pkg::PEND_FINE] && !wr;
	endsequence

	a_coarse_load: assert property (pt_coarse && allow && pend_out[tpuc_pkg::PEND_COARSE] && !wr
		|=> !pend_out[tpuc_pkg::PEND_COARSE] && work_out.coarse == $past(shadow_q.coarse))
		else $error("coarse exposure not loaded at first dark line");
	a_tilt_load: assert property (pt_tilt && allow && pend_out[tpuc_pkg::PEND_TILT] && !wr
		|=> !pend_out[tpuc_pkg::PEND_TILT] && work_out.voff == $past(shadow_q.voff))
		else $error("tilt not loaded at first visible line");
	a_gain_eof: assert property (pt_eof && allow && pend_out[tpuc_pkg::PEND_GAIN] && !wr
		|=> !pend_out[tpuc_pkg::PEND_GAIN] && work_out.gain == $past(shadow_q.gain))
		else $error("gain not loaded at EOF line");
	a_gain_inhibit: assert property (burst_out && pt_eof && pend_out[tpuc_pkg::PEND_GAIN] && !msg_end
		|=> pend_out[tpuc_pkg::PEND_GAIN])
		else $error("gain loaded during auto-increment message");
	a_burst_hold: assert property (burst_out && !msg_end |=> $stable(work_out))
		else $error("working register changed during message");
	a_line_track: assert property (s_line_write |=> line_chg_q)
		else $error("line length change not tracked");
	a_fine_linelen: assert property (s_fine_oe ##0 line_chg_q
		|=> !pend_out[tpuc_pkg::PEND_FINE] && work_out.fine == $past(shadow_q.fine))
		else $error("fine exposure missed odd-to-even load");
	a_fine_eof: assert property (pt_eof && allow && !line_chg_q && pend_out[tpuc_pkg::PEND_FINE] && !wr
		|=> !pend_out[tpuc_pkg::PEND_FINE])
		else $error("fine exposure missed EOF load");
	a_video_oe: assert property (pt_oe && allow && pend_out[tpuc_pkg::PEND_VIDEO] && !wr
		|=> !pend_out[tpuc_pkg::PEND_VIDEO] && !line_chg_q && work_out.line_len == $past(shadow_q.line_len))
		else $error("video timing not loaded at odd-to-even");
	a_gain_imm: assert property (msg_end && gain_imm_in && pend_out[tpuc_pkg::PEND_GAIN]
		|=> !pend_out[tpuc_pkg::PEND_GAIN] && work_out.gain == $past(shadow_q.gain))
		else $error("immediate gain not applied at message end");
	a_field_parity: assert property (field_start_in |=> field_odd_out != $past(field_odd_out))
		else $error("field parity did not toggle");
	a_clkdiv_mode: assert property (wr && wa == tpuc_pkg::ADDR_PRIMARY_SETUP
		|=> shadow_q.clkdiv[7:4] == clkdiv_hi($past(wd)))
		else $error("clock divisor upper nibble not set from mode");
	a_pend_hold: assert property (pend_out[tpuc_pkg::PEND_PAN] && !(allow && pt_eof)
		|=> pend_out[tpuc_pkg::PEND_PAN])
		else $error("pan pending cleared without a load");
endmodule : tpuc_update_ctrl
`default_nettype wire

// >>> test/tpuc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tpuc_host_model (
	input wire logic clk_link_in,
	input wire logic link_busy_in,
	input wire logic link_rsp_valid_in,
	input wire logic [7:0] link_rsp_data_in,
	output logic link_valid_out,
	output tpuc_pkg::tpuc_req_t link_pkt_out
);
	initial begin
		link_valid_out = 1'b0;
		link_pkt_out = '0;
	end

	// ==========================================================
	// One request in flight; strobe drops at the taking edge so it is not taken twice
	task automatic xfer(input tpuc_pkg::tpuc_kind_t k, input logic ai, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic ok);
		int n;
		n = 0;
		@(posedge clk_link_in);
		link_valid_out <= 1'b1;
		link_pkt_out <= '{k, ai, a, d};
		// Held until an edge finds the link idle, which is the taking edge
		do begin
			@(posedge clk_link_in);
			n++;
		end while (link_busy_in && n < 40);
		link_valid_out <= 1'b0;
		// Released bus shows garbage, never the old request
		link_pkt_out <= tpuc_pkg::tpuc_req_t'(~link_pkt_out);
		do begin
			@(posedge clk_link_in);
			n++;
		end while (!link_rsp_valid_in && n < 80);
		rd = link_rsp_data_in;
		ok = link_rsp_valid_in;
		@(posedge clk_link_in);
	endtask : xfer
endmodule : tpuc_host_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk_sys_in = 1'b0;
	logic clk_link_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic gain_imm = 1'b0;
	logic clkdiv_imm = 1'b0;
	logic [4:0] tim = 5'h00;
	logic busy, rsp_v, vld, odd, burst, ok;
	logic [7:0] rsp_d, rd_q;
	logic [6:0] pend;
	tpuc_pkg::tpuc_req_t pkt;
	tpuc_pkg::tpuc_regs_t work;
	int mismatches = 0;
	int n_checks = 0;
	always #10 clk_sys_in = ~clk_sys_in;
	initial begin
		#7;
		forever #40 clk_link_in = ~clk_link_in;
	end
	tpuc_update_ctrl tpuc_update_ctrl_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .clk_link_in(clk_link_in),
		.link_valid_in(vld), .link_pkt_in(pkt), .link_busy_out(busy), .link_rsp_valid_out(rsp_v),
		.link_rsp_data_out(rsp_d), .gain_imm_in(gain_imm), .clkdiv_imm_in(clkdiv_imm), .field_start_in(tim[4]),
		.sav_in(tim[3]), .line_first_dark_in(tim[2]), .line_first_visible_in(tim[1]), .line_eof_in(tim[0]),
		.work_out(work), .pend_out(pend), .field_odd_out(odd), .burst_out(burst));
	tpuc_host_model tpuc_host_model_inst (.clk_link_in(clk_link_in), .link_busy_in(busy),
		.link_rsp_valid_in(rsp_v), .link_rsp_data_in(rsp_d), .link_valid_out(vld), .link_pkt_out(pkt));

	// ==========================================================
	// Shared helpers
	task automatic tally_and_finish();
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [175:0] got, input logic [175:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask : chk
	task automatic req(input tpuc_pkg::tpuc_kind_t k, input logic ai, input logic [7:0] a, input logic [7:0] d);
		tpuc_host_model_inst.xfer(k, ai, a, d, rd_q, ok);
		if (!ok) begin
			mismatches++;
			tally_and_finish();
		end
	endtask : req
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ai);
		req(tpuc_pkg::REQ_WRITE, ai, a, d);
	endtask : wr
	// Timing markers {field_start, sav, dark, visible, eof}, one cycle
	task automatic pt(input logic [4:0] v);
		@(posedge clk_sys_in);
		tim <= v;
		@(posedge clk_sys_in);
		tim <= 5'h00;
		repeat (2) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask : pt

	// ==========================================================
	// Scenarios
	task automatic t_writes();
		chk("reset pend", pend, 7'h00);
		wr(8'h20, 8'h12, 1'b0);
		wr(8'h23, 8'h34, 1'b0);
		wr(8'h24, 8'h56, 1'b0);
		wr(8'h25, 8'h05, 1'b0);
		wr(8'h58, 8'h78, 1'b0);
		wr(8'h5a, 8'h9a, 1'b0);
		wr(8'h53, 8'hbc, 1'b0);
		wr(8'h02, 8'h00, 1'b0);
		chk("pend all", pend, 7'h7f);
		chk("work idle", work, 176'h0);
		req(tpuc_pkg::REQ_READ, 1'b0, 8'h02, 8'h00);
		chk("status", rd_q, 8'h7f);
	endtask : t_writes
	task automatic t_order();
		pt(5'h10);
		chk("odd", odd, 1'b1);
		pt(5'h0c);
		chk("coarse", {pend, work.coarse}, {7'h7d, 16'h0034});
		pt(5'h0a);
		chk("tilt", {pend, work.voff}, {7'h5d, 16'h009a});
		pt(5'h09);
		chk("eof", {pend, work.gain, work.hoff, work.fine}, {7'h45, 8'h56, 16'h0078, 16'h0});
		pt(5'h10);
		chk("o2e", {odd, pend, work.fine, work.clkdiv, work.line_len}, {1'b0, 7'h0, 16'h1200, 8'h05, 16'h00bc});
	endtask : t_order
	task automatic t_burst();
		pt(5'h10);
		wr(8'h24, 8'ha1, 1'b1);
		wr(8'h21, 8'h22, 1'b1);
		pt(5'h09);
		chk("held", {burst, pend, work.gain}, {1'b1, 7'h09, 8'h56});
		req(tpuc_pkg::REQ_MSG_END, 1'b0, 8'h00, 8'h00);
		chk("timed", {burst, pend}, {1'b0, 7'h09});
		pt(5'h09);
		chk("late", {pend, work.gain, work.fine}, {7'h0, 8'ha1, 16'h1222});
	endtask : t_burst
	task automatic t_imm();
		@(posedge clk_sys_in);
		gain_imm <= 1'b1;
		clkdiv_imm <= 1'b1;
		wr(8'h24, 8'h3c, 1'b1);
		wr(8'h25, 8'h0a, 1'b1);
		wr(8'h22, 8'h07, 1'b1);
		req(tpuc_pkg::REQ_MSG_END, 1'b0, 8'h00, 8'h00);
		chk("imm", {pend, work.gain, work.clkdiv}, {7'h02, 8'h3c, 8'h0a});
	endtask : t_imm
	task automatic t_mode();
		wr(8'h10, 8'h01, 1'b0);
		chk("mode pend", {pend[6], pend[5:4]}, 3'b100);
		req(tpuc_pkg::REQ_READ, 1'b0, 8'h25, 8'h00);
		chk("clkdiv", rd_q, 8'h1a);
		req(tpuc_pkg::REQ_READ, 1'b0, 8'h7f, 8'h00);
		chk("unmapped", rd_q, 8'h00);
	endtask : t_mode

	initial begin
		repeat (8) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		t_writes();
		t_order();
		t_burst();
		t_imm();
		t_mode();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
